/* adcs_pkg.sv */
// Package of constants and types for the converter control sequencer
package adcs_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam int          ADDR_W            = 12;
  localparam logic [7:0]  IDX_CONV_CTRL     = 8'h1F;
  localparam logic [7:0]  IDX_PORT_CFG      = 8'h9F;
  localparam logic [7:0]  IDX_RESULT_HIGH   = 8'hA0;
  localparam logic [7:0]  IDX_RESULT_LOW    = 8'hA1;
  localparam logic [7:0]  IDX_IRQ_STATUS    = 8'hA2;
  localparam logic [7:0]  IDX_IRQ_MASK      = 8'hA3;
  localparam logic [11:0] ADDR_CONV_CTRL    = {2'b00, IDX_CONV_CTRL, 2'b00};
  localparam logic [11:0] ADDR_PORT_CFG     = {2'b00, IDX_PORT_CFG, 2'b00};
  localparam logic [11:0] ADDR_RESULT_HIGH  = {2'b00, IDX_RESULT_HIGH, 2'b00};
  localparam logic [11:0] ADDR_RESULT_LOW   = {2'b00, IDX_RESULT_LOW, 2'b00};
  localparam logic [11:0] ADDR_IRQ_STATUS   = {2'b00, IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] ADDR_IRQ_MASK     = {2'b00, IDX_IRQ_MASK, 2'b00};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_CLK_SEL_LSB = 6;
  localparam int CTRL_CHAN_LSB    = 3;
  localparam int CTRL_GO_BIT      = 2;
  localparam int CTRL_POWER_BIT   = 0;
  localparam int CFG_JUSTIFY_BIT  = 7;
  localparam int IRQ_DONE_BIT     = 0;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_RESET        = 8'h00;
  localparam logic [7:0]  CFG_RESET         = 8'h00;
  localparam logic [9:0]  RESULT_RESET      = 10'h000;
  localparam int          RESULT_BITS       = 10;
  localparam logic [3:0]  SAR_LAST_BIT      = 4'h9;
  localparam logic [5:0]  DIV2_LAST         = 6'h01;
  localparam logic [5:0]  DIV8_LAST         = 6'h07;
  localparam logic [5:0]  DIV32_LAST        = 6'h1F;

  // Conversion clock sources
  typedef enum logic [1:0] {
    ADCS_CLK_DIV2  = 2'h0,
    ADCS_CLK_DIV8  = 2'h1,
    ADCS_CLK_DIV32 = 2'h2,
    ADCS_CLK_RC    = 2'h3
  } adcs_clk_sel_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ADCS_IDLE    = 3'b001,
    ADCS_SAMPLE  = 3'b010,
    ADCS_CONVERT = 3'b100
  } adcs_state_t;

  // Pin mapping toward the port pins
  typedef struct packed {
    logic [7:0] analog_en;
    logic       vref_hi_pin;
    logic       vref_lo_pin;
  } adcs_pin_map_t;

  // Controls toward the converter core
  typedef struct packed {
    logic       sample;
    logic [2:0] channel;
    logic [9:0] trial;
  } adcs_core_t;

endpackage : adcs_pkg

/* adcs_sar.sv */
// Successive-approximation sequencer for one conversion
`timescale 1ns/1ps
`default_nettype none
module adcs_sar
  import adcs_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       tick,
  input  wire logic       comp_above,
  output logic            busy,
  output logic            sample,
  output logic            done,
  output logic [9:0]      trial,
  output logic [9:0]      result
);

  adcs_state_t state;
  logic [3:0]  bit_idx;

  // ----------------------------------------------------------------
  // Sample then resolve one bit per conversion bit time
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state   <= ADCS_IDLE;
      bit_idx <= 4'h0;
      trial   <= 10'h000;
      result  <= RESULT_RESET;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        state <= ADCS_IDLE;
        trial <= 10'h000;
      end else begin
        case (state)
          ADCS_IDLE: begin
            if (start) begin
              state <= ADCS_SAMPLE;
            end
          end
          ADCS_SAMPLE: begin
            if (tick) begin
              state   <= ADCS_CONVERT;
              bit_idx <= SAR_LAST_BIT;
              trial   <= 10'h200;
            end
          end
          ADCS_CONVERT: begin
            if (tick) begin
              // Drop the trial bit when the input is below it
              if (bit_idx == 4'h0) begin
                state  <= ADCS_IDLE;
                done   <= 1'b1;
                result <= comp_above ? trial : (trial & ~10'h001);
                trial  <= 10'h000;
              end else begin
                trial   <= (comp_above ? trial : (trial & ~(10'h001 << bit_idx)))
                           | (10'h001 << (bit_idx - 4'h1));
                bit_idx <= bit_idx - 4'h1;
              end
            end
          end
          default: begin
            state <= ADCS_IDLE;
          end
        endcase
      end
    end
  end

  assign busy   = (state != ADCS_IDLE);
  assign sample = (state == ADCS_SAMPLE);

  property p_done_from_convert;
    @(posedge core_clk) disable iff (rst)
    $rose(done) |-> $past(state) == ADCS_CONVERT && $past(bit_idx) == 4'h0;
  endproperty
  a_done_from_convert: assert property (p_done_from_convert) else $error("done without last bit");

endmodule : adcs_sar
`default_nettype wire

/* adcs_top.sv */
// Converter control sequencer: APB registers, clocking, pin map, interrupt
//
// Operation
// - Five or eight analog input channels
// - Sample input, resolve 10-bit successive approximation
// - References from rails or porta_pin2/porta_pin3
// - Sleep conversions only on internal RC clock
// - Six registers: result pair, control, config, interrupt status, interrupt mask
// - Config sets pins analog, digital or reference
// - Channel select bits 5-3 pick channel
// - Right justify zeroes high byte upper six
// - Left justify zeroes low byte lower six
// - Done: load result, clear go, set flag
// - Pin config bits 3-0 select map, refs
`timescale 1ns/1ps
`default_nettype none
module adcs_top
  import adcs_pkg::*;
#(
  parameter int NUM_CHANNELS = 8
)(
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 sleep,
  input  wire logic                 rc_tick,
  input  wire logic                 comp_above,
  output adcs_pkg::adcs_core_t      core_ctrl,
  output adcs_pkg::adcs_pin_map_t   pin_map,
  output logic                      irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0]    clk_sel;
  logic [2:0]    channel_sel;
  logic          conv_go_flag;
  logic          conv_power_on;
  logic          result_justify;
  logic [3:0]    pin_config_sel;
  logic [9:0]    result_raw;
  logic          irq_status;
  logic          irq_mask;
  logic [5:0]    div_cnt;
  logic [5:0]    div_last;
  logic          conv_tick;
  logic          wr_en;
  logic          rd_en;
  logic          go_write;
  logic          start;
  logic          abort;
  logic          sar_busy;
  logic          sar_sample;
  logic          sar_done;
  logic [9:0]    sar_trial;
  logic [9:0]    sar_result;
  logic [7:0]    ctrl_rd;
  logic [7:0]    cfg_rd;
  logic [7:0]    res_hi_rd;
  logic [7:0]    res_lo_rd;
  logic          addr_ok;
  logic [7:0]    next_rd;
  adcs_pin_map_t next_pin_map;

  // ----------------------------------------------------------------
  // Pin map lookup
  // ----------------------------------------------------------------
  // Analog enables for AN7..AN0 and the two reference pins
  function automatic adcs_pin_map_t pin_lookup(input logic [3:0] sel);
    adcs_pin_map_t m;
    m = '{analog_en: 8'h00, vref_hi_pin: 1'b0, vref_lo_pin: 1'b0};
    case (sel)
      4'h0: m = '{analog_en: 8'hFF, vref_hi_pin: 1'b0, vref_lo_pin: 1'b0};
      4'h1: m = '{analog_en: 8'hF7, vref_hi_pin: 1'b1, vref_lo_pin: 1'b0};
      4'h2: m = '{analog_en: 8'h1F, vref_hi_pin: 1'b0, vref_lo_pin: 1'b0};
      4'h3: m = '{analog_en: 8'h17, vref_hi_pin: 1'b1, vref_lo_pin: 1'b0};
      4'h4: m = '{analog_en: 8'h0B, vref_hi_pin: 1'b0, vref_lo_pin: 1'b0};
      4'h5: m = '{analog_en: 8'h03, vref_hi_pin: 1'b1, vref_lo_pin: 1'b0};
      4'h6: m = '{analog_en: 8'h00, vref_hi_pin: 1'b0, vref_lo_pin: 1'b0};
      4'h7: m = '{analog_en: 8'h00, vref_hi_pin: 1'b0, vref_lo_pin: 1'b0};
      4'h8: m = '{analog_en: 8'hF3, vref_hi_pin: 1'b1, vref_lo_pin: 1'b1};
      4'h9: m = '{analog_en: 8'h3F, vref_hi_pin: 1'b0, vref_lo_pin: 1'b0};
      4'hA: m = '{analog_en: 8'h37, vref_hi_pin: 1'b1, vref_lo_pin: 1'b0};
      4'hB: m = '{analog_en: 8'h33, vref_hi_pin: 1'b1, vref_lo_pin: 1'b1};
      4'hC: m = '{analog_en: 8'h13, vref_hi_pin: 1'b1, vref_lo_pin: 1'b1};
      4'hD: m = '{analog_en: 8'h03, vref_hi_pin: 1'b1, vref_lo_pin: 1'b1};
      4'hE: m = '{analog_en: 8'h01, vref_hi_pin: 1'b0, vref_lo_pin: 1'b0};
      default: m = '{analog_en: 8'h01, vref_hi_pin: 1'b1, vref_lo_pin: 1'b1};
    endcase
    return m;
  endfunction : pin_lookup

  // ----------------------------------------------------------------
  // Bus strobes
  // ----------------------------------------------------------------
  // Accept on the first access cycle, while pready is still low
  assign wr_en    = psel && penable && !pready && pwrite && addr_ok;
  assign rd_en    = psel && penable && !pready && !pwrite;
  assign go_write = wr_en && (paddr == ADDR_CONV_CTRL);
  assign start    = go_write && pwdata[CTRL_GO_BIT] && pwdata[CTRL_POWER_BIT]
                    && !sar_busy;
  assign abort    = sar_busy && ((go_write && !pwdata[CTRL_GO_BIT]) || !conv_power_on);

  // Address decode
  always_comb begin
    if (paddr == ADDR_CONV_CTRL) begin
      addr_ok = 1'b1;
    end else if (paddr == ADDR_PORT_CFG) begin
      addr_ok = 1'b1;
    end else if (paddr == ADDR_RESULT_HIGH) begin
      addr_ok = 1'b1;
    end else if (paddr == ADDR_RESULT_LOW) begin
      addr_ok = 1'b1;
    end else if (paddr == ADDR_IRQ_STATUS) begin
      addr_ok = 1'b1;
    end else if (paddr == ADDR_IRQ_MASK) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_sel       <= CTRL_RESET[7:6];
      channel_sel   <= CTRL_RESET[5:3];
      conv_power_on <= CTRL_RESET[0];
    end else if (go_write) begin
      clk_sel       <= pwdata[CTRL_CLK_SEL_LSB +: 2];
      channel_sel   <= pwdata[CTRL_CHAN_LSB +: 3];
      conv_power_on <= pwdata[CTRL_POWER_BIT];
    end
  end

  // Go flag: a start in the completion cycle must not be lost
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      conv_go_flag <= CTRL_RESET[2];
    end else if (start) begin
      conv_go_flag <= 1'b1;
    end else if (sar_done || abort) begin
      conv_go_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Port configuration register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      result_justify <= CFG_RESET[7];
      pin_config_sel <= CFG_RESET[3:0];
    end else if (wr_en && paddr == ADDR_PORT_CFG) begin
      result_justify <= pwdata[CFG_JUSTIFY_BIT];
      pin_config_sel <= pwdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------
  // Division chosen by clock select
  always_comb begin
    case (clk_sel)
      ADCS_CLK_DIV2:  div_last = DIV2_LAST;
      ADCS_CLK_DIV8:  div_last = DIV8_LAST;
      default:        div_last = DIV32_LAST;
    endcase
  end

  // System clock divider; held at zero in sleep
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 6'h00;
    end else if (!sar_busy || sleep || div_cnt >= div_last) begin
      div_cnt <= 6'h00;
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  // Bit time tick: RC runs in sleep, system divisions do not
  always_comb begin
    if (clk_sel == ADCS_CLK_RC) begin
      conv_tick = rc_tick;
    end else begin
      conv_tick = !sleep && (div_cnt == div_last);
    end
  end

  // ----------------------------------------------------------------
  // Approximation engine
  // ----------------------------------------------------------------
  adcs_sar u_sar (
    .core_clk   (core_clk),
    .rst        (rst),
    .start      (start),
    .abort      (abort),
    .tick       (conv_tick),
    .comp_above (comp_above),
    .busy       (sar_busy),
    .sample     (sar_sample),
    .done       (sar_done),
    .trial      (sar_trial),
    .result     (sar_result)
  );

  // Result pair loads on completion
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      result_raw <= RESULT_RESET;
    end else if (sar_done) begin
      result_raw <= sar_result;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  // Completion wins over a same-cycle write-one clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_status <= 1'b0;
    end else if (sar_done) begin
      irq_status <= 1'b1;
    end else if (wr_en && paddr == ADDR_IRQ_STATUS && pwdata[IRQ_DONE_BIT]) begin
      irq_status <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_mask <= 1'b0;
    end else if (wr_en && paddr == ADDR_IRQ_MASK) begin
      irq_mask <= pwdata[IRQ_DONE_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_status && irq_mask;
    end
  end

  // ----------------------------------------------------------------
  // Outputs toward pins and core
  // ----------------------------------------------------------------
  // Channels beyond the fitted count go digital from the first clock after reset; reset drives all eight analog
  always_comb begin
    next_pin_map = pin_lookup(pin_config_sel);
    for (int i = NUM_CHANNELS; i < 8; i++) begin
      next_pin_map.analog_en[i] = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_map   <= '{analog_en: 8'hFF, vref_hi_pin: 1'b0, vref_lo_pin: 1'b0};
      core_ctrl <= '{sample: 1'b0, channel: 3'h0, trial: 10'h000};
    end else begin
      pin_map   <= next_pin_map;
      core_ctrl <= '{sample: sar_sample, channel: channel_sel, trial: sar_trial};
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  assign ctrl_rd   = {clk_sel, channel_sel, conv_go_flag, 1'b0, conv_power_on};
  assign cfg_rd    = {result_justify, 3'b000, pin_config_sel};
  assign res_hi_rd = result_justify ? {6'h00, result_raw[9:8]} : result_raw[9:2];
  assign res_lo_rd = result_justify ? result_raw[7:0] : {result_raw[1:0], 6'h00};

  always_comb begin
    if (paddr == ADDR_CONV_CTRL) begin
      next_rd = ctrl_rd;
    end else if (paddr == ADDR_PORT_CFG) begin
      next_rd = cfg_rd;
    end else if (paddr == ADDR_RESULT_HIGH) begin
      next_rd = res_hi_rd;
    end else if (paddr == ADDR_RESULT_LOW) begin
      next_rd = res_lo_rd;
    end else if (paddr == ADDR_IRQ_STATUS) begin
      next_rd = {7'h00, irq_status};
    end else if (paddr == ADDR_IRQ_MASK) begin
      next_rd = {7'h00, irq_mask};
    end else begin
      next_rd = 8'h00;
    end
  end

  // One wait state, then ready with data or error
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !addr_ok;
      prdata  <= rd_en ? {24'h000000, next_rd} : 32'h0000_0000;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_done_clears_go;
    @(posedge core_clk) disable iff (rst)
    sar_done && !start |=> !conv_go_flag && irq_status && result_raw == $past(sar_result);
  endproperty
  a_done_clears_go: assert property (p_done_clears_go) else $error("completion effects missing");

  property p_start_needs_power;
    @(posedge core_clk) disable iff (rst)
    start |-> pwdata[CTRL_POWER_BIT] ##1 conv_go_flag && conv_power_on;
  endproperty
  a_start_needs_power: assert property (p_start_needs_power) else $error("start without power");

  property p_bit1_zero;
    @(posedge core_clk) disable iff (rst)
    rd_en && paddr == ADDR_CONV_CTRL |=> pready && prdata[1] == 1'b0;
  endproperty
  a_bit1_zero: assert property (p_bit1_zero) else $error("control bit 1 not zero");

  property p_right_justify;
    @(posedge core_clk) disable iff (rst)
    rd_en && paddr == ADDR_RESULT_HIGH && result_justify
      |=> prdata[7:2] == 6'h00 && prdata[1:0] == $past(result_raw[9:8]);
  endproperty
  a_right_justify: assert property (p_right_justify) else $error("right justify high byte wrong");

  property p_left_justify;
    @(posedge core_clk) disable iff (rst)
    rd_en && paddr == ADDR_RESULT_LOW && !result_justify
      |=> prdata[5:0] == 6'h00 && prdata[7:6] == $past(result_raw[1:0]);
  endproperty
  a_left_justify: assert property (p_left_justify) else $error("left justify low byte wrong");

  property p_sleep_rc_only;
    @(posedge core_clk) disable iff (rst)
    sleep && clk_sel != ADCS_CLK_RC |-> !conv_tick;
  endproperty
  a_sleep_rc_only: assert property (p_sleep_rc_only) else $error("bit tick in sleep off RC");

  property p_all_digital;
    @(posedge core_clk) disable iff (rst)
    pin_config_sel[3:1] == 3'b011 |=> pin_map.analog_en == 8'h00 && !pin_map.vref_hi_pin;
  endproperty
  a_all_digital: assert property (p_all_digital) else $error("digital map not applied");

  property p_ref_pins;
    @(posedge core_clk) disable iff (rst)
    pin_config_sel == 4'h8 |=> pin_map.vref_hi_pin && pin_map.vref_lo_pin && !pin_map.analog_en[3];
  endproperty
  a_ref_pins: assert property (p_ref_pins) else $error("reference pins not selected");

  property p_channel_out;
    @(posedge core_clk) disable iff (rst)
    ##1 core_ctrl.channel == $past(channel_sel);
  endproperty
  a_channel_out: assert property (p_channel_out) else $error("channel not driven");

  property p_div2_rate;
    @(posedge core_clk) disable iff (rst)
    conv_tick && clk_sel == ADCS_CLK_DIV2 && !sleep && sar_busy && !start && !abort
      |=> !conv_tick ##1 (conv_tick || !sar_busy || sleep || $changed(clk_sel));
  endproperty
  a_div2_rate: assert property (p_div2_rate) else $error("divide-by-two tick spacing wrong");

endmodule : adcs_top
`default_nettype wire

/* adcs_core_model.sv */
// Behavioural comparator and RC bit clock behind the converter
`timescale 1ns/1ps
`default_nettype none
module adcs_core_model
  import adcs_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire adcs_pkg::adcs_core_t core_ctrl,
  input  wire logic [9:0]           vin,
  output logic                      comp_above,
  output logic                      rc_tick
);
  logic [1:0] rc_cnt;

  // ----------------------------------------
  // Comparator and RC oscillator
  // ----------------------------------------
  // Held input at or above the trial code
  assign comp_above = (vin >= core_ctrl.trial);
  // RC bit time pulse every third clock
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rc_cnt <= 2'h0;
    end else begin
      rc_cnt <= (rc_cnt == 2'h2) ? 2'h0 : rc_cnt + 2'h1;
    end
  end
  assign rc_tick = (rc_cnt == 2'h2);
endmodule : adcs_core_model
`default_nettype wire

/* adc_control_sequencer_tb_top.sv */
// Self-checking bench for the converter control sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_control_sequencer_tb_top;
  import adcs_pkg::*;
  logic              core_clk, rst, psel, penable, pwrite, sleep;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rnd;
  logic              pready, pslverr, rc_tick, comp_above, irq;
  logic [9:0]        vin;
  adcs_core_t        core_ctrl;
  adcs_pin_map_t     pin_map;
  logic [33:0]       exp_q[$];
  logic [33:0]       e;
  int                mismatches, checks_done, k;
  logic [3:0]        codes [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h9, 4'hE, 4'h8};
  logic [9:0]        maps [8] = '{10'h3FC, 10'h07C, 10'h02C, 10'h000, 10'h000, 10'h0FC, 10'h004, 10'h3CF};

  adcs_top uut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep(sleep), .rc_tick(rc_tick), .comp_above(comp_above),
    .core_ctrl(core_ctrl), .pin_map(pin_map), .irq(irq));
  adcs_core_model core (.core_clk(core_clk), .rst(rst), .core_ctrl(core_ctrl),
    .vin(vin), .comp_above(comp_above), .rc_tick(rc_tick));

  // ----------------------------------------
  // Clock and helpers
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // One APB transfer; expectation noted before it starts
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic err, input logic [31:0] ex);
    int n;
    exp_q.push_back({~wr, err, ex});
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 32'h0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0, 1'b0, ex);
  endtask : rd
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 1000) begin
      mismatches++;
      give_verdict();
    end
  endtask : wait_irq
  // One conversion of a random level, then result readback
  task automatic conv(input logic [1:0] cs, input logic [2:0] ch, input logic j);
    logic [9:0] r;
    repeat (70) @(posedge core_clk);
    rnd = xs(rnd);
    r = rnd[9:0];
    vin <= r;
    wr(ADDR_PORT_CFG, {24'h0, j, 7'h0});
    wr(ADDR_CONV_CTRL, {24'h0, cs, ch, 3'b101});
    @(posedge core_clk);
    chk("sample", 32'h1, {31'h0, core_ctrl.sample});
    @(posedge core_clk);
    chk("channel", {29'h0, ch}, {29'h0, core_ctrl.channel});
    wait_irq();
    rd(ADDR_CONV_CTRL, {24'h0, cs, ch, 3'b001});
    rd(ADDR_RESULT_HIGH, j ? {30'h0, r[9:8]} : {24'h0, r[9:2]});
    rd(ADDR_RESULT_LOW, j ? {24'h0, r[7:0]} : {24'h0, r[1:0], 6'h0});
    rd(ADDR_IRQ_STATUS, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h1);
    rd(ADDR_IRQ_STATUS, 32'h0);
  endtask : conv

  // ----------------------------------------
  // Monitor: oldest note against each answer
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (pready === 1'b1) begin
      e = exp_q.pop_front();
      chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
      if (e[33]) begin
        chk("prdata", e[31:0], prdata);
      end
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, sleep} = 4'h0;
    paddr = '0;
    pwdata = 32'h0;
    vin = 10'h0;
    rnd = 32'hCDA6;
    mismatches = 0;
    checks_done = 0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    chk("analog_en", 32'hFF, {24'h0, pin_map.analog_en});
    rd(ADDR_CONV_CTRL, 32'h0);
    rd(ADDR_PORT_CFG, 32'h0);
    rd(ADDR_RESULT_HIGH, 32'h0);
    rd(ADDR_RESULT_LOW, 32'h0);
    wr(ADDR_CONV_CTRL, 32'hFA);
    rd(ADDR_CONV_CTRL, 32'hF8);
    wr(ADDR_PORT_CFG, 32'hFF);
    rd(ADDR_PORT_CFG, 32'h8F);
    apb(1'b0, 12'h100, 32'h0, 1'b1, 32'h0);
    for (k = 0; k < 8; k++) begin
      wr(ADDR_PORT_CFG, {28'h0, codes[k]});
      repeat (2) @(posedge core_clk);
      chk("pin_map", {22'h0, maps[k]}, {22'h0, pin_map});
    end
    wr(ADDR_IRQ_MASK, 32'h1);
    rd(ADDR_IRQ_MASK, 32'h1);
    for (k = 0; k < 4; k++) begin
      sleep <= (k == 3);
      conv(k[1:0], 3'(k * 2 + 1), k[0]);
    end
    // Sleep stalls a divided clock conversion
    sleep <= 1'b1;
    wr(ADDR_CONV_CTRL, 32'h05);
    repeat (60) @(posedge core_clk);
    chk("irq", 32'h0, {31'h0, irq});
    sleep <= 1'b0;
    wait_irq();
    wr(ADDR_IRQ_STATUS, 32'h1);
    // Go without power, then an abort
    wr(ADDR_CONV_CTRL, 32'h04);
    repeat (60) @(posedge core_clk);
    rd(ADDR_IRQ_STATUS, 32'h0);
    wr(ADDR_CONV_CTRL, 32'h45);
    repeat (10) @(posedge core_clk);
    wr(ADDR_CONV_CTRL, 32'h41);
    repeat (200) @(posedge core_clk);
    rd(ADDR_IRQ_STATUS, 32'h0);
    give_verdict();
  end
endmodule : adc_control_sequencer_tb_top
`default_nettype wire
